// ---- alsu_mem_model.sv ----
// behavioural word memory and constant table beyond the unit
`timescale 1ns/1ps
module alsu_mem_model
    import alsu_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  ackWait,
    input  wire logic        memReq,
    input  wire logic        memWe,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWdata,
    output logic      [15:0] memRdata,
    output logic             memAck,
    input  wire logic        constReq,
    input  wire logic [15:0] constLabel,
    input  wire logic [15:0] constIndex,
    output logic      [15:0] constData,
    output logic             constAck
);
    logic [15:0] mem [256];
    logic        used [256];
    logic [3:0]  waitCnt;
    wire         pend = (memReq && !memAck) || (constReq && !constAck);
    // unwritten words read as the inverted address; only 256 words kept
    always @(posedge sys_clk) begin
        memAck    <= 1'b0;
        constAck  <= 1'b0;
        memRdata  <= ~memRdata;
        constData <= ~constData;
        if (!rst_b) begin
            waitCnt   <= 4'h0;
            memRdata  <= 16'h0000;
            constData <= 16'h0000;
            for (int i = 0; i < 256; i++) used[i] <= 1'b0;
        end else if (pend && waitCnt != ackWait) begin
            waitCnt <= waitCnt + 4'h1;
        end else if (pend) begin
            waitCnt   <= 4'h0;
            memAck    <= memReq;
            constAck  <= constReq && !memReq;
            constData <= constLabel ^ constIndex;
            memRdata  <= used[memAddr[7:0]] ? mem[memAddr[7:0]] : ~memAddr;
            if (memReq && memWe) begin
                mem[memAddr[7:0]]  <= memWdata;
                used[memAddr[7:0]] <= 1'b1;
            end
        end
    end
endmodule

// ---- alsu_monitor.sv ----
// port-level assertions for the accumulator load/store unit
`timescale 1ns/1ps
module alsu_monitor
    import alsu_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        opValid,
    input wire alsu_op_e    opCode,
    input wire logic [15:0] opAddr,
    input wire logic [31:0] opImm,
    input wire logic        opBusy,
    input wire logic        opDone,
    input wire logic        memReq,
    input wire logic        memWe,
    input wire logic [15:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic [15:0] memRdata,
    input wire logic        memAck,
    input wire logic [15:0] constData,
    input wire logic        constAck,
    input wire logic        bitWe,
    input wire logic [15:0] bitAddr,
    input wire logic        bitData,
    input wire logic [31:0] accum,
    input wire logic [31:0] stackTop,
    input wire logic        zeroLoadFlag
);
    alsu_op_e    lastOp_q;
    logic [15:0] base_q;
    logic [31:0] imm_q;
    logic [31:0] pop_q;
    logic        prevLd_q;
    wire  [4:0]  bitIdx = bitAddr[4:0] - base_q[4:0];
    function automatic logic isLd(alsu_op_e o);
        return o inside {OP_INDEXED_WORD_LOAD, OP_INDEXED_CONSTANT_LOAD,
            OP_REAL_VALUE_LOAD_MEM, OP_REAL_VALUE_LOAD_IMM,
            OP_OCTAL_ADDRESS_LOAD};
    endfunction
    // ops are latched at acceptance since the inputs need not be held
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            lastOp_q <= OP_NONE;
            base_q   <= 16'h0000;
            imm_q    <= 32'h0000_0000;
            pop_q    <= 32'h0000_0000;
            prevLd_q <= 1'b0;
        end else if (opValid && !opBusy) begin
            lastOp_q <= opCode;
            base_q   <= opAddr;
            imm_q    <= opImm;
            pop_q    <= stackTop;
            prevLd_q <= isLd(opCode);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence sAccept;
        opValid && !opBusy;
    endsequence
    sequence sLoadAfterLoad;
        sAccept ##0 (isLd(opCode) && prevLd_q);
    endsequence
    // busy must drop right after the done pulse or the next load is lost
    sequence sDoneThenIdle;
        opBusy ##1 !opBusy;
    endsequence
    AST_IDX_DATA: assert property (
        memAck && lastOp_q == OP_INDEXED_WORD_LOAD
        |=> accum == {16'h0000, $past(memRdata)})
        else $error("index load");
    AST_ZERO: assert property (
        opDone && isLd(lastOp_q)
        |-> zeroLoadFlag == (accum == 32'h0000_0000))
        else $error("zero flag");
    AST_PUSH: assert property (
        sLoadAfterLoad |=> stackTop == $past(accum))
        else $error("no push");
    AST_TAKE: assert property (
        sAccept |=> opBusy)
        else $error("busy not raised");
    AST_BUSY: assert property (
        opDone |-> sDoneThenIdle)
        else $error("busy not dropped");
    AST_CONST: assert property (
        constAck |=> accum == {16'h0000, $past(constData)})
        else $error("const");
    AST_REAL: assert property (
        opDone && lastOp_q == OP_REAL_VALUE_LOAD_IMM |-> accum == imm_q)
        else $error("real load");
    AST_STORE: assert property (
        memReq && memWe |-> $stable(accum) && memWdata
        == (memAddr == base_q ? accum[15:0] : accum[31:16]))
        else $error("store data");
    AST_BITS: assert property (
        bitWe |-> bitData == accum[bitIdx])
        else $error("bit data");
    AST_POP: assert property (
        opDone && lastOp_q == OP_POP |-> accum == pop_q)
        else $error("pop");
endmodule
bind alsu_top alsu_monitor alsu_monitor_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .opValid(opValid), .opCode(opCode), .opAddr(opAddr), .opImm(opImm),
    .opBusy(opBusy), .opDone(opDone), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memAck(memAck), .constData(constData), .constAck(constAck),
    .bitWe(bitWe), .bitAddr(bitAddr), .bitData(bitData), .accum(accum),
    .stackTop(stackTop), .zeroLoadFlag(zeroLoadFlag));

// ---- alsu_pkg.sv ----
// constants, operation codes and states of the accumulator load/store unit
package alsu_pkg;
    localparam int          ALSU_ACC_W     = 32;
    localparam int          ALSU_WORD_W    = 16;
    localparam int          ALSU_STACK_LVL = 8;
    localparam int          ALSU_OCT_DIG   = 6;
    localparam int          ALSU_OCT_W     = 18;
    localparam int          ALSU_CNT_W     = 6;
    localparam logic [31:0] ALSU_ACC_RST   = 32'h0000_0000;
    localparam logic [15:0] ALSU_WORD_RST  = 16'h0000;
    localparam logic [15:0] ALSU_ADDR_STEP = 16'h0001;
    localparam logic [15:0] ALSU_HI_CLEAR  = 16'h0000;
    localparam logic [5:0]  ALSU_BITS_MIN  = 6'h01;
    localparam logic [5:0]  ALSU_BITS_MAX  = 6'h20;
    localparam logic [5:0]  ALSU_CNT_RST   = 6'h00;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_INDEXED_WORD_LOAD,
        OP_INDEXED_CONSTANT_LOAD,
        OP_REAL_VALUE_LOAD_MEM,
        OP_REAL_VALUE_LOAD_IMM,
        OP_WORD_STORE,
        OP_DOUBLE_WORD_STORE,
        OP_FORMATTED_BIT_STORE,
        OP_POP,
        OP_OCTAL_ADDRESS_LOAD
    } alsu_op_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_LO,
        ST_RD_HI,
        ST_CONST_RD,
        ST_WR_LO,
        ST_WR_HI,
        ST_BITS,
        ST_DONE
    } alsu_state_e;
endpackage

// ---- alsu_stack.sv ----
// eight-level accumulator stack, push moves levels down, pop moves them up
`timescale 1ns/1ps
module alsu_stack
    import alsu_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire logic                  push,
    input  wire logic                  pop,
    input  wire logic [ALSU_ACC_W-1:0] pushData,
    output logic      [ALSU_ACC_W-1:0] levelOne
);
    logic [ALSU_ACC_W-1:0] lvl_q [ALSU_STACK_LVL];

    assign levelOne = lvl_q[0];

    genvar i;
    generate
        for (i = 0; i < ALSU_STACK_LVL; i++) begin : g_lvl
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    lvl_q[i] <= ALSU_ACC_RST;
                end else if (push) begin
                    if (i == 0) begin
                        lvl_q[i] <= pushData;
                    end else begin
                        lvl_q[i] <= lvl_q[(i == 0) ? 0 : i - 1];
                    end
                end else if (pop) begin
                    // bottom level keeps its value; it is don't-care after pop
                    if (i < ALSU_STACK_LVL - 1) begin
                        lvl_q[i] <= lvl_q[(i < ALSU_STACK_LVL - 1) ? i + 1 : i];
                    end
                end
            end
        end
    endgenerate
endmodule

// ---- alsu_top.sv ----
// accumulator load and store datapath with stack, zero flag and memory ports
`timescale 1ns/1ps
// What this block does
// - indexed load reads word at base plus level-one offset into low half
// - indexed 16-bit load clears upper accumulator half
// - every load sets zero flag when loaded value is zero, else clears it
// - load right after a load first pushes accumulator onto the stack
// - constant load picks one constant by level-one offset into low half
// - constant load names its label area by a number 1 to FFFF
// - real load fills whole accumulator from two words or immediate
// - word store writes low accumulator half, accumulator unchanged
// - double store writes all 32 bits into two consecutive words
// - formatted store writes 1 to 32 low bits to consecutive bits
// - pop moves level one into accumulator and shifts stack up
// - octal address load converts octal operand to binary
module alsu_top
    import alsu_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire logic                   opValid,
    input  wire alsu_op_e               opCode,
    input  wire logic [ALSU_WORD_W-1:0] opAddr,
    input  wire logic [ALSU_ACC_W-1:0]  opImm,
    input  wire logic [ALSU_CNT_W-1:0]  bitCount,
    output logic                        opBusy,
    output logic                        opDone,
    output logic                        memReq,
    output logic                        memWe,
    output logic      [ALSU_WORD_W-1:0] memAddr,
    output logic      [ALSU_WORD_W-1:0] memWdata,
    input  wire logic [ALSU_WORD_W-1:0] memRdata,
    input  wire logic                   memAck,
    output logic                        constReq,
    output logic      [ALSU_WORD_W-1:0] constLabel,
    output logic      [ALSU_WORD_W-1:0] constIndex,
    input  wire logic [ALSU_WORD_W-1:0] constData,
    input  wire logic                   constAck,
    output logic                        bitWe,
    output logic      [ALSU_WORD_W-1:0] bitAddr,
    output logic                        bitData,
    output logic      [ALSU_ACC_W-1:0]  accum,
    output logic      [ALSU_ACC_W-1:0]  stackTop,
    output logic                        zeroLoadFlag
);
    alsu_state_e            state_q;
    alsu_state_e            state_d;
    logic [ALSU_ACC_W-1:0]  acc_q;
    logic                   zero_q;
    logic                   lastLoad_q;
    logic [ALSU_WORD_W-1:0] lowHold_q;
    logic [ALSU_CNT_W-1:0]  idx_q;
    logic [ALSU_CNT_W-1:0]  lastIdx_q;
    logic                   realRead_q;
    logic                   opDone_q;
    logic                   opBusy_q;
    logic                   memReq_q;
    logic                   memWe_q;
    logic [ALSU_WORD_W-1:0] memAddr_q;
    logic [ALSU_WORD_W-1:0] memWdata_q;
    logic                   constReq_q;
    logic [ALSU_WORD_W-1:0] constLabel_q;
    logic [ALSU_WORD_W-1:0] constIndex_q;
    logic                   bitWe_q;
    logic [ALSU_WORD_W-1:0] bitAddr_q;
    logic                   bitData_q;
    logic [ALSU_ACC_W-1:0]  levelOne;
    logic                   accept;
    logic                   isLoadOp;
    logic                   loadEn;
    logic                   popEn;
    logic [ALSU_ACC_W-1:0]  accVal;
    logic [ALSU_WORD_W-1:0] offset;
    logic                   badCount;
    logic [ALSU_OCT_W-1:0]  octPart [ALSU_OCT_DIG+1];

    assign accept   = (state_q == ST_IDLE) && opValid;
    assign isLoadOp = (opCode == OP_INDEXED_WORD_LOAD)
                   || (opCode == OP_INDEXED_CONSTANT_LOAD)
                   || (opCode == OP_REAL_VALUE_LOAD_MEM)
                   || (opCode == OP_REAL_VALUE_LOAD_IMM)
                   || (opCode == OP_OCTAL_ADDRESS_LOAD);
    // after a back-to-back load the old accumulator becomes level one
    assign offset   = lastLoad_q ? acc_q[15:0] : levelOne[15:0];
    assign badCount = (bitCount < ALSU_BITS_MIN)
                   || (bitCount > ALSU_BITS_MAX);

    // octal digits arrive one per nibble; only the low three bits count
    assign octPart[0] = '0;
    genvar g;
    generate
        for (g = 0; g < ALSU_OCT_DIG; g++) begin : g_oct
            assign octPart[g+1] = octPart[g]
                + (ALSU_OCT_W'(opImm[4*g +: 3]) << (3 * g));
        end
    endgenerate

    alsu_stack u_stack (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .push     (accept && isLoadOp && lastLoad_q),
        .pop      (popEn),
        .pushData (acc_q),
        .levelOne (levelOne)
    );

    always_comb begin
        loadEn = 1'b0;
        popEn  = 1'b0;
        accVal = acc_q;
        if (accept && opCode == OP_REAL_VALUE_LOAD_IMM) begin
            loadEn = 1'b1;
            accVal = opImm;
        end else if (accept && opCode == OP_OCTAL_ADDRESS_LOAD) begin
            loadEn = 1'b1;
            accVal = {ALSU_HI_CLEAR, octPart[ALSU_OCT_DIG][15:0]};
        end else if (accept && opCode == OP_POP) begin
            popEn  = 1'b1;
            accVal = levelOne;
        end else if (state_q == ST_RD_LO && memAck && !realRead_q) begin
            loadEn = 1'b1;
            accVal = {ALSU_HI_CLEAR, memRdata};
        end else if (state_q == ST_RD_HI && memAck) begin
            loadEn = 1'b1;
            accVal = {memRdata, lowHold_q};
        end else if (state_q == ST_CONST_RD && constAck) begin
            loadEn = 1'b1;
            accVal = {ALSU_HI_CLEAR, constData};
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (opValid) begin
                    case (opCode)
                        OP_INDEXED_WORD_LOAD:     state_d = ST_RD_LO;
                        OP_REAL_VALUE_LOAD_MEM:   state_d = ST_RD_LO;
                        OP_INDEXED_CONSTANT_LOAD: state_d = ST_CONST_RD;
                        OP_WORD_STORE:            state_d = ST_WR_LO;
                        OP_DOUBLE_WORD_STORE:     state_d = ST_WR_LO;
                        OP_FORMATTED_BIT_STORE:
                            state_d = badCount ? ST_DONE : ST_BITS;
                        default:                  state_d = ST_DONE;
                    endcase
                end
            end
            ST_RD_LO:    if (memAck) state_d = realRead_q ? ST_RD_HI : ST_DONE;
            ST_RD_HI:    if (memAck) state_d = ST_DONE;
            ST_CONST_RD: if (constAck) state_d = ST_DONE;
            ST_WR_LO:    if (memAck) state_d = realRead_q ? ST_WR_HI : ST_DONE;
            ST_WR_HI:    if (memAck) state_d = ST_DONE;
            ST_BITS:     if (idx_q == lastIdx_q) state_d = ST_DONE;
            ST_DONE:     state_d = ST_IDLE;
            default:     state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q  <= ST_IDLE;
            opDone_q <= 1'b0;
            opBusy_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            opDone_q <= (state_d == ST_DONE);
            opBusy_q <= (state_d != ST_IDLE);
        end
    end

    // accumulator and zero flag; pop and stores leave the flag alone
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            acc_q      <= ALSU_ACC_RST;
            zero_q     <= 1'b0;
            lastLoad_q <= 1'b0;
        end else begin
            if (loadEn || popEn) begin
                acc_q <= accVal;
            end
            if (loadEn) begin
                zero_q <= (accVal == ALSU_ACC_RST);
            end
            if (accept) begin
                lastLoad_q <= isLoadOp;
            end
        end
    end

    // word memory port; request holds until acknowledged
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            memReq_q   <= 1'b0;
            memWe_q    <= 1'b0;
            memAddr_q  <= ALSU_WORD_RST;
            memWdata_q <= ALSU_WORD_RST;
            lowHold_q  <= ALSU_WORD_RST;
            realRead_q <= 1'b0;
        end else if (accept) begin
            realRead_q <= (opCode == OP_REAL_VALUE_LOAD_MEM)
                       || (opCode == OP_DOUBLE_WORD_STORE);
            memWdata_q <= acc_q[15:0];
            memAddr_q  <= opAddr;
            case (opCode)
                OP_INDEXED_WORD_LOAD: begin
                    memReq_q  <= 1'b1;
                    memWe_q   <= 1'b0;
                    memAddr_q <= opAddr + offset;
                end
                OP_REAL_VALUE_LOAD_MEM: begin
                    memReq_q <= 1'b1;
                    memWe_q  <= 1'b0;
                end
                OP_WORD_STORE, OP_DOUBLE_WORD_STORE: begin
                    memReq_q <= 1'b1;
                    memWe_q  <= 1'b1;
                end
                default: memReq_q <= 1'b0;
            endcase
        end else if (memAck && (state_q == ST_RD_LO || state_q == ST_WR_LO)
                     && realRead_q) begin
            lowHold_q  <= memRdata;
            memAddr_q  <= memAddr_q + ALSU_ADDR_STEP;
            memWdata_q <= acc_q[31:16];
        end else if (memAck) begin
            memReq_q <= 1'b0;
            memWe_q  <= 1'b0;
        end
    end

    // constant area port: label picks the area, offset picks the entry
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            constReq_q   <= 1'b0;
            constLabel_q <= ALSU_WORD_RST;
            constIndex_q <= ALSU_WORD_RST;
        end else if (accept && opCode == OP_INDEXED_CONSTANT_LOAD) begin
            constReq_q   <= 1'b1;
            constLabel_q <= opAddr;
            constIndex_q <= offset;
        end else if (constAck) begin
            constReq_q <= 1'b0;
        end
    end

    // one discrete bit per cycle; bad counts end the store with no write
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bitWe_q   <= 1'b0;
            bitAddr_q <= ALSU_WORD_RST;
            bitData_q <= 1'b0;
            idx_q     <= ALSU_CNT_RST;
            lastIdx_q <= ALSU_CNT_RST;
        end else if (accept && opCode == OP_FORMATTED_BIT_STORE) begin
            bitWe_q   <= !badCount;
            bitAddr_q <= opAddr;
            bitData_q <= acc_q[0];
            idx_q     <= ALSU_BITS_MIN;
            lastIdx_q <= bitCount;
        end else if (state_q == ST_BITS && idx_q != lastIdx_q) begin
            bitAddr_q <= bitAddr_q + ALSU_ADDR_STEP;
            bitData_q <= acc_q[idx_q[4:0]];
            idx_q     <= idx_q + ALSU_BITS_MIN;
        end else begin
            bitWe_q <= 1'b0;
        end
    end

    assign opBusy       = opBusy_q;
    assign opDone       = opDone_q;
    assign memReq       = memReq_q;
    assign memWe        = memWe_q;
    assign memAddr      = memAddr_q;
    assign memWdata     = memWdata_q;
    assign constReq     = constReq_q;
    assign constLabel   = constLabel_q;
    assign constIndex   = constIndex_q;
    assign bitWe        = bitWe_q;
    assign bitAddr      = bitAddr_q;
    assign bitData      = bitData_q;
    assign accum        = acc_q;
    assign stackTop     = levelOne;
    assign zeroLoadFlag = zero_q;
endmodule

// ---- testbench.sv ----
// directed scenarios for the accumulator load/store unit
`timescale 1ns/1ps
module testbench;
    import alsu_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        opValid = 1'b0;
    alsu_op_e    opCode = OP_NONE;
    logic [15:0] opAddr = 16'h0000;
    logic [31:0] opImm = 32'h0000_0000;
    logic [5:0]  bitCount = 6'h00;
    logic [3:0]  slow = 4'h0;
    logic        opDone, memReq, memWe, memAck, constReq, constAck;
    logic        bitWe, bitData, zeroLoadFlag;
    logic [15:0] memAddr, memWdata, memRdata, constLabel, constIndex;
    logic [15:0] constData, bitAddr;
    logic [31:0] accum, stackTop, bits;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    alsu_top alsu_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .opValid(opValid),
        .opCode(opCode), .opAddr(opAddr), .opImm(opImm), .bitCount(bitCount),
        .opBusy(), .opDone(opDone), .memReq(memReq), .memWe(memWe),
        .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
        .memAck(memAck), .constReq(constReq), .constLabel(constLabel),
        .constIndex(constIndex), .constData(constData), .constAck(constAck),
        .bitWe(bitWe), .bitAddr(bitAddr), .bitData(bitData), .accum(accum),
        .stackTop(stackTop), .zeroLoadFlag(zeroLoadFlag));
    alsu_mem_model alsu_mem_model_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .ackWait(slow), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
        .constReq(constReq), .constLabel(constLabel),
        .constIndex(constIndex), .constData(constData), .constAck(constAck));
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (bitWe) bits[bitAddr[4:0]] <= bitData;
        if (cycles == 20000) begin
            bad_count++;
            $display("[ERR] %0t run timed out", $time);
            end_sim();
        end
    end
    task end_sim;
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // one op per call; a hung op counts as a mismatch and ends the run
    task run_op(alsu_op_e op, logic [15:0] a, logic [31:0] imm, logic [5:0] n);
        int k;
        @(posedge sys_clk);
        #1;
        opValid = 1'b1;
        opCode = op;
        opAddr = a;
        opImm = imm;
        bitCount = n;
        @(posedge sys_clk);
        #1;
        opValid = 1'b0;
        k = 0;
        while (opDone !== 1'b1 && k < 200) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k == 200) begin
            bad_count++;
            $display("[ERR] %0t op never finished", $time);
            end_sim();
        end
    endtask
    task t_octal;
        run_op(OP_OCTAL_ADDRESS_LOAD, 16'h0000, 32'h0004_0400, 6'h00);
        check(accum, 32'h0000_4100);
        check({31'h0, zeroLoadFlag}, 32'h0);
        run_op(OP_OCTAL_ADDRESS_LOAD, 16'h0000, 32'h0000_0025, 6'h00);
        check(accum, 32'h0000_0015);
        check(stackTop, 32'h0000_4100);
    endtask
    task t_index;
        slow = 4'h3;
        run_op(OP_INDEXED_WORD_LOAD, 16'h0010, 32'h0, 6'h00);
        check(accum, 32'h0000_FFDA);
        check(stackTop, 32'h0000_0015);
        run_op(OP_OCTAL_ADDRESS_LOAD, 16'h0000, 32'h0000_0001, 6'h00);
        run_op(OP_INDEXED_WORD_LOAD, 16'hFFFE, 32'h0, 6'h00);
        check(accum, 32'h0000_0000);
        check({31'h0, zeroLoadFlag}, 32'h1);
    endtask
    task t_const;
        slow = 4'h0;
        run_op(OP_OCTAL_ADDRESS_LOAD, 16'h0000, 32'h0000_0001, 6'h00);
        run_op(OP_INDEXED_CONSTANT_LOAD, 16'h0001, 32'h0, 6'h00);
        check({31'h0, zeroLoadFlag}, 32'h1);
        run_op(OP_INDEXED_CONSTANT_LOAD, 16'hFFFF, 32'h0, 6'h00);
        check(accum, 32'h0000_FFFF);
        check({31'h0, zeroLoadFlag}, 32'h0);
    endtask
    task t_real;
        run_op(OP_REAL_VALUE_LOAD_IMM, 16'h0000, 32'h4049_0FDB, 6'h00);
        check(accum, 32'h4049_0FDB);
        slow = 4'h2;
        run_op(OP_REAL_VALUE_LOAD_MEM, 16'h0030, 32'h0, 6'h00);
        check(accum, 32'hFFCE_FFCF);
    endtask
    // stored words are read back through the partner's memory
    task t_store;
        run_op(OP_WORD_STORE, 16'h0040, 32'h0, 6'h00);
        check(accum, 32'hFFCE_FFCF);
        run_op(OP_DOUBLE_WORD_STORE, 16'h0050, 32'h0, 6'h00);
        run_op(OP_REAL_VALUE_LOAD_MEM, 16'h0050, 32'h0, 6'h00);
        check(accum, 32'hFFCE_FFCF);
        run_op(OP_REAL_VALUE_LOAD_MEM, 16'h0040, 32'h0, 6'h00);
        check(accum, 32'hFFBE_FFCF);
    endtask
    task t_bits;
        bits = 32'h0000_0000;
        run_op(OP_FORMATTED_BIT_STORE, 16'h0020, 32'h0, 6'h20);
        check(bits, 32'hFFBE_FFCF);
        bits = 32'h0000_0000;
        run_op(OP_FORMATTED_BIT_STORE, 16'h0020, 32'h0, 6'h01);
        check(bits, 32'h0000_0001);
        run_op(OP_FORMATTED_BIT_STORE, 16'h0020, 32'h0, 6'h00);
        run_op(OP_FORMATTED_BIT_STORE, 16'h0020, 32'h0, 6'h21);
        check(bits, 32'h0000_0001);
    endtask
    task t_pop;
        run_op(OP_OCTAL_ADDRESS_LOAD, 16'h0000, 32'h0000_0007, 6'h00);
        run_op(OP_OCTAL_ADDRESS_LOAD, 16'h0000, 32'h0000_0003, 6'h00);
        check(stackTop, 32'h0000_0007);
        run_op(OP_POP, 16'h0000, 32'h0, 6'h00);
        check(accum, 32'h0000_0007);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        t_octal();
        t_index();
        t_const();
        t_real();
        t_store();
        t_bits();
        t_pop();
        end_sim();
    end
endmodule
